// ### src/sms_pkg.sv
/*
 * Constants, parameter encodings, register map and timing counts for the
 * service-mode supervisor.
 * Assumes a single 10 MHz clock and the plain register port.
 */
package sms_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int FILT_TIME_US = 1000;
	localparam int FILT_CYCLES = (CLK_HZ / 1_000_000) * FILT_TIME_US;
	localparam int FILT_W = 14;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_EDIT = 4'h1;
	localparam logic [3:0] ADDR_SAVE = 4'h2;
	localparam logic [3:0] ADDR_ACTIVE = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;

	// Control register fields
	localparam int CTRL_SAFE_BIT = 0;
	localparam int CTRL_SERIAL_BIT = 1;
	localparam int CTRL_WATCH_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h5;

	// Parameter set fields: level[1:0], speed[2], source[4:3]
	localparam int PAR_LEVEL_LSB = 0;
	localparam int PAR_SPEED_BIT = 2;
	localparam int PAR_SRC_LSB = 3;
	localparam logic [4:0] PAR_RESET = 5'h00;
	localparam logic [7:0] SAVE_KEY = 8'hA5;

	// Status fields
	localparam int ST_SERVICE_BIT = 0;
	localparam int ST_PAUSE_BIT = 1;
	localparam int ST_DIRTY_BIT = 2;
	localparam int ST_SUPPLY_BIT = 3;

	localparam logic [1:0] SRC_PENDANT = 2'h0;
	localparam logic [1:0] SRC_PEND_DED = 2'h1;
	localparam logic [1:0] SRC_PEND_ONL = 2'h2;
	localparam logic [1:0] SRC_ALL = 2'h3;

	typedef enum logic [0:0] {SMS_NORMAL, SMS_SERVICE} sms_mode_e;

	function automatic logic sms_src_ok(input logic [1:0] sel, input int kind);
		// kind 1: dedicated inputs, kind 2: online commands
		sms_src_ok = (kind == 1) ? (sel == SRC_PEND_DED || sel == SRC_ALL) :
			(sel == SRC_PEND_ONL || sel == SRC_ALL);
	endfunction

endpackage

// ### src/sms_filter.sv
/*
 * Contact input synchroniser and debounce filter.
 * Assumes inputs may bounce; output changes only after a stable run.
 */
module sms_filter
	import sms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic raw,
	output logic clean
);
	logic sync1;
	logic sync2;
	logic [FILT_W-1:0] cnt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end else if (ce) begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	// Open contact at reset: fail toward the restricted state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clean <= 1'b0;
			cnt <= '0;
		end else if (ce) begin
			if (sync2 == clean) begin
				cnt <= '0;
			end else if (cnt == FILT_W'(FILT_CYCLES - 1)) begin
				clean <= sync2; // RULE12
				cnt <= '0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

endmodule

// ### src/sms_params.sv
/*
 * Edit and active copies of the service parameters.
 * Assumes a save strobe from the register port; reset stands for power-off.
 */
module sms_params
	import sms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic edit_we,
	input wire logic [4:0] edit_data,
	input wire logic save,
	output logic [4:0] edit_set,
	output logic [4:0] active_set
);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			edit_set <= PAR_RESET;
		end else if (ce && edit_we) begin
			edit_set <= edit_data;
		end
	end

	// Edits reach the active copy only on save; unsaved ones die at reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			active_set <= PAR_RESET; // RULE11
		end else if (ce && save) begin
			active_set <= edit_set; // RULE11
		end
	end

endmodule

// ### src/sms_top.sv
/*
 * Service-mode supervisor: picks normal or service state from the contact
 * inputs and supply watch, and applies the active service parameters.
 * Assumes contacts read 1 when closed and all inputs share clk_sys.
 */
// Summary of operation
// (RULE1) An open standard contact selects service, closed keeps normal.
// (RULE2) With the serial board, either contact open selects service.
// (RULE3) Service restricts operation only while safe mode is set.
// (RULE4) The level gives hold-to-run in bit 0, auto prohibition in bit 1.
// (RULE5) With hold-to-run, motion is allowed only while the key is held.
// (RULE6) Default speed setting caps speed below 3%, the other sets none.
// (RULE7) Source setting selects which command sources are accepted.
// (RULE8) With the serial board, dedicated inputs come from serial lines.
// (RULE9) A change of the service input pauses running or jogging motion.
// (RULE10) In safe mode a missing 24 V supply forces service if watched.
// (RULE11) Edited parameters act only once saved and are lost at power-off.
// (RULE12) Contact inputs are synchronised and debounced before use.
module sms_top
	import sms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic std_service_contact,
	input wire logic serial_service_contact,
	input wire logic supply_24v_ok,
	input wire logic pendant_key_held,
	input wire logic program_running,
	input wire logic jog_active,
	input wire logic auto_request,
	input wire logic ded_cmd_parallel,
	input wire logic ded_cmd_serial,
	input wire logic online_cmd,
	input wire logic pause_ack,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic service_active,
	output logic motion_permit,
	output logic auto_permit,
	output logic speed_limit_3pct,
	output logic ded_cmd_accept,
	output logic online_cmd_accept,
	output logic motion_pause
);
	logic std_clean;
	logic ser_clean;
	logic sup_clean;
	logic [2:0] ctrl;
	logic [4:0] edit_set;
	logic [4:0] active_set;
	logic save;
	logic contact_open;
	logic supply_forced;
	logic next_service;
	logic svc_in_q;
	logic svc_in;
	sms_mode_e mode;
	logic [1:0] level;
	logic [1:0] src_sel;
	logic ded_cmd;

	sms_filter u_flt_std (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.raw(std_service_contact),
		.clean(std_clean)
	);

	sms_filter u_flt_ser (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.raw(serial_service_contact),
		.clean(ser_clean)
	);

	sms_filter u_flt_sup (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.raw(supply_24v_ok),
		.clean(sup_clean)
	);

	assign save = reg_wr && reg_addr == ADDR_SAVE && reg_wdata == SAVE_KEY;

	sms_params u_params (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.edit_we(reg_wr && reg_addr == ADDR_EDIT),
		.edit_data(reg_wdata[4:0]),
		.save(save),
		.edit_set(edit_set),
		.active_set(active_set)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
		end else if (ce && reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl <= reg_wdata[2:0];
		end
	end

	// Mode selection
	always_comb begin
		contact_open = !std_clean; // RULE1
		if (ctrl[CTRL_SERIAL_BIT]) begin
			contact_open = !std_clean || !ser_clean; // RULE2
		end
	end

	assign supply_forced = ctrl[CTRL_WATCH_BIT] && !sup_clean; // RULE10
	assign svc_in = contact_open || supply_forced;

	always_comb begin
		next_service = ctrl[CTRL_SAFE_BIT] && svc_in; // RULE3
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode <= SMS_SERVICE;
		end else if (ce) begin
			case (mode)
				SMS_NORMAL: begin
					if (next_service) begin
						mode <= SMS_SERVICE;
					end
				end
				SMS_SERVICE: begin
					if (!next_service) begin
						mode <= SMS_NORMAL;
					end
				end
				default: begin
					mode <= SMS_SERVICE;
				end
			endcase
		end
	end

	// Pause on any change of the filtered service input while moving
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			svc_in_q <= 1'b1;
		end else if (ce) begin
			svc_in_q <= svc_in;
		end
	end

	// Set wins over the acknowledge in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			motion_pause <= 1'b0;
		end else if (ce) begin
			if (svc_in != svc_in_q && (program_running || jog_active)) begin
				motion_pause <= 1'b1; // RULE9
			end else if (pause_ack) begin
				motion_pause <= 1'b0;
			end
		end
	end

	assign level = active_set[PAR_LEVEL_LSB +: 2];
	assign src_sel = active_set[PAR_SRC_LSB +: 2];
	assign ded_cmd = ctrl[CTRL_SERIAL_BIT] ? ded_cmd_serial
		: ded_cmd_parallel; // RULE8

	// Registered permissions toward motion control
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			service_active <= 1'b1;
			motion_permit <= 1'b0;
			auto_permit <= 1'b0;
			speed_limit_3pct <= 1'b1;
			ded_cmd_accept <= 1'b0;
			online_cmd_accept <= 1'b0;
		end else if (ce) begin
			service_active <= (mode == SMS_SERVICE);
			if (mode == SMS_SERVICE) begin
				motion_permit <= !motion_pause &&
					(!level[0] || pendant_key_held); // RULE5
				auto_permit <= auto_request && !level[1]; // RULE4
				speed_limit_3pct <= !active_set[PAR_SPEED_BIT]; // RULE6
				ded_cmd_accept <= ded_cmd && sms_src_ok(src_sel, 1); // RULE7
				online_cmd_accept <= online_cmd && sms_src_ok(src_sel, 2); // RULE7
			end else begin
				motion_permit <= !motion_pause;
				auto_permit <= auto_request;
				speed_limit_3pct <= 1'b0;
				ded_cmd_accept <= ded_cmd;
				online_cmd_accept <= online_cmd;
			end
		end
	end

	// Register read port: data one cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_CTRL: reg_rdata <= {5'h00, ctrl};
					ADDR_EDIT: reg_rdata <= {3'h0, edit_set};
					ADDR_ACTIVE: reg_rdata <= {3'h0, active_set};
					ADDR_STATUS: begin
						reg_rdata[ST_SERVICE_BIT] <= service_active;
						reg_rdata[ST_PAUSE_BIT] <= motion_pause;
						reg_rdata[ST_DIRTY_BIT] <= edit_set != active_set;
						reg_rdata[ST_SUPPLY_BIT] <= sup_clean;
					end
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Assertions
	AST_NORMAL_CLOSED: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		ce && std_clean && (!ctrl[CTRL_SERIAL_BIT] || ser_clean) &&
		!supply_forced |=> mode == SMS_NORMAL)
		else $error("closed contacts did not give normal mode");

	AST_SERIAL_OPEN: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
		ce && ctrl[CTRL_SAFE_BIT] && ctrl[CTRL_SERIAL_BIT] && !ser_clean
		|=> mode == SMS_SERVICE)
		else $error("open serial contact did not give service");

	AST_UNSAFE_NORMAL: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
		ce && !ctrl[CTRL_SAFE_BIT] |=> mode == SMS_NORMAL)
		else $error("service entered outside safe mode");

	AST_AUTO_BLOCK: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
		ce && mode == SMS_SERVICE && level[1] |=> !auto_permit)
		else $error("auto allowed at prohibiting level");

	sequence s_hold_released;
		ce && mode == SMS_SERVICE && level[0] && !pendant_key_held;
	endsequence
	AST_HOLD_TO_RUN: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		s_hold_released |=> !motion_permit)
		else $error("motion without pendant key held");

	AST_SPEED: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
		ce && mode == SMS_SERVICE |=>
		speed_limit_3pct == !$past(active_set[PAR_SPEED_BIT]))
		else $error("speed cap does not follow setting");

	AST_SOURCE: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
		ce && mode == SMS_SERVICE && src_sel == SRC_PENDANT |=>
		!ded_cmd_accept && !online_cmd_accept)
		else $error("non-pendant source accepted");

	AST_SERIAL_DED: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
		ce && mode == SMS_NORMAL && ctrl[CTRL_SERIAL_BIT] |=>
		ded_cmd_accept == $past(ded_cmd_serial))
		else $error("dedicated input not from serial lines");

	sequence s_input_change;
		ce && svc_in != svc_in_q && (program_running || jog_active);
	endsequence
	AST_PAUSE: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
		s_input_change |=> motion_pause ##1 (!ce || !motion_permit))
		else $error("no pause on service input change");

	AST_SUPPLY: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
		ce && ctrl[CTRL_SAFE_BIT] && ctrl[CTRL_WATCH_BIT] && !sup_clean
		|=> mode == SMS_SERVICE)
		else $error("missing supply did not force service");

	AST_NO_SAVE: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		!(ce && save) |=> $stable(active_set))
		else $error("active set changed without save");

	AST_SAVE_COPY: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		ce && save |=> active_set == $past(edit_set))
		else $error("save did not copy the edit set");

	AST_SERVICE_OUT: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		ce |=> service_active == ($past(mode) == SMS_SERVICE))
		else $error("service output does not follow mode");

	AST_AUTO_FREE: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
		ce && mode == SMS_SERVICE && !level[1] |=>
		auto_permit == $past(auto_request))
		else $error("auto blocked at permitting level");

	sequence s_no_hold;
		ce && mode == SMS_SERVICE && !level[0];
	endsequence
	AST_HOLD_FREE: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		s_no_hold |=> motion_permit == !$past(motion_pause))
		else $error("motion gated without hold-to-run");

	AST_SRC_DED: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
		ce && mode == SMS_SERVICE && src_sel == SRC_PEND_DED |=>
		!online_cmd_accept)
		else $error("online command accepted outside its set");

	AST_PAR_DED: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
		ce && mode == SMS_NORMAL && !ctrl[CTRL_SERIAL_BIT] |=>
		ded_cmd_accept == $past(ded_cmd_parallel))
		else $error("dedicated input not from parallel lines");

	AST_PAUSE_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
		ce && motion_pause && !pause_ack |=> motion_pause)
		else $error("pause dropped without acknowledge");

	AST_UNWATCHED: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
		ce && ctrl[CTRL_SAFE_BIT] && !ctrl[CTRL_WATCH_BIT] && !contact_open
		|=> mode == SMS_NORMAL)
		else $error("unwatched supply still forced service");

endmodule

// ### bench/sms_partner.sv
/*
 * Contact model for the service inputs: every commanded change of a
 * contact arrives with a short burst of bounce before it settles.
 * Assumes the bench sets the commanded levels at rising clock edges.
 */
module sms_partner (
	input wire logic clk_sys,
	input wire logic std_cmd,
	input wire logic ser_cmd,
	output logic std_service_contact,
	output logic serial_service_contact
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] bounce = 4'h0;
	logic std_q = 1'b1;
	logic ser_q = 1'b0;
	// Bounce much shorter than the filter span must not move the mode
	always @(posedge clk_sys) begin
		std_q <= std_cmd;
		ser_q <= ser_cmd;
		if (std_q != std_cmd || ser_q != ser_cmd)
			bounce <= 4'hF;
		else if (bounce != 4'h0)
			bounce <= bounce - 4'h1;
	end
	assign std_service_contact = bounce[0] ? ~std_cmd : std_cmd;
	assign serial_service_contact = bounce[0] ? ~ser_cmd : ser_cmd;
endmodule

// ### bench/sms_top_tb.sv
/*
 * Self-checking bench for the service-mode supervisor, register port
 * tasks plus contact model. Assumes the filter span from the package.
 */
module sms_top_tb;
	import sms_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FW = FILT_CYCLES + 50;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic std_cmd = 1'b0;
	logic ser_cmd = 1'b0;
	logic std_c, ser_c;
	logic supply = 1'b1, key = 1'b0, prog = 1'b0, auto_req = 1'b0;
	logic dedp = 1'b0, deds = 1'b0, onl = 1'b0, ack = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic ce = 1'b1, jog = 1'b0;
	logic [7:0] rdata;
	logic svc, mp, ap, spd, dacc, oacc, mpause;
	int err_total = 0;
	int tests_run = 0;
	logic [7:0] ed;

	always #50 clk_sys = ~clk_sys;

	sms_partner u_partner (.clk_sys(clk_sys), .std_cmd(std_cmd),
		.ser_cmd(ser_cmd), .std_service_contact(std_c),
		.serial_service_contact(ser_c));

	sms_top u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.std_service_contact(std_c), .serial_service_contact(ser_c),
		.supply_24v_ok(supply), .pendant_key_held(key),
		.program_running(prog), .jog_active(jog), .auto_request(auto_req),
		.ded_cmd_parallel(dedp), .ded_cmd_serial(deds), .online_cmd(onl),
		.pause_ack(ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.service_active(svc), .motion_permit(mp), .auto_permit(ap),
		.speed_limit_3pct(spd), .ded_cmd_accept(dacc),
		.online_cmd_accept(oacc), .motion_pause(mpause));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(rdata, exp);
	endtask

	// Bounded wait on the mode output, then compare it
	task automatic wait_svc(input logic exp, input int n);
		for (int i = 0; i < n && svc !== exp; i++)
			@(posedge clk_sys);
		@(negedge clk_sys);
		chk({7'h00, svc}, {7'h00, exp});
	endtask

	task automatic settle;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#8_000_000;
		err_total++;
		finish_test();
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk({svc, spd, mp, ap}, 4'hC);
		rd_reg(ADDR_CTRL, 8'h05);
		rd_reg(4'hF, 8'h00);
		wr_reg(ADDR_EDIT, 8'h03);
		rd_reg(ADDR_ACTIVE, 8'h00);
		rd_reg(ADDR_STATUS, 8'h05);
		wr_reg(ADDR_SAVE, 8'h5A);
		rd_reg(ADDR_ACTIVE, 8'h00);
		wr_reg(ADDR_SAVE, SAVE_KEY);
		rd_reg(ADDR_ACTIVE, 8'h03);
		tdone("registers");
		@(posedge clk_sys);
		std_cmd <= 1'b1;
		wait_svc(1'b0, FW);
		wr_reg(ADDR_CTRL, 8'h07);
		wait_svc(1'b1, 10);
		@(posedge clk_sys);
		ser_cmd <= 1'b1;
		wait_svc(1'b0, FW);
		tdone("contacts");
		@(posedge clk_sys);
		{prog, auto_req, dedp, deds, onl} <= 5'h1F;
		std_cmd <= 1'b0;
		wait_svc(1'b1, FW);
		settle();
		chk({mpause, mp}, 2'h2);
		@(posedge clk_sys);
		ack <= 1'b1;
		@(posedge clk_sys);
		ack <= 1'b0;
		key <= 1'b1;
		settle();
		chk({mpause, mp}, 2'h1);
		@(posedge clk_sys);
		key <= 1'b0;
		settle();
		chk({mp, ap}, 2'h0);
		chk({spd, dacc, oacc}, 3'h4);
		tdone("service level 3");
		@(posedge clk_sys);
		dedp <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			ed = {3'h0, i[1:0], 1'b1, i[1:0]};
			wr_reg(ADDR_EDIT, ed);
			wr_reg(ADDR_SAVE, SAVE_KEY);
			settle();
			chk({mp, ap}, {~ed[0], ~ed[1]});
			chk({spd, dacc, oacc}, {1'b0, ed[3], ed[4]});
		end
		@(posedge clk_sys);
		{dedp, deds} <= 2'h2;
		settle();
		chk(dacc, 1'b0);
		tdone("parameter sets");
		@(posedge clk_sys);
		prog <= 1'b0;
		wr_reg(ADDR_CTRL, 8'h06);
		wait_svc(1'b0, 10);
		settle();
		chk({ap, spd}, 2'h2);
		wr_reg(ADDR_CTRL, 8'h07);
		wait_svc(1'b1, 10);
		@(posedge clk_sys);
		std_cmd <= 1'b1;
		supply <= 1'b0;
		repeat (FW) @(posedge clk_sys);
		wait_svc(1'b1, 1);
		rd_reg(ADDR_STATUS, 8'h01);
		@(posedge clk_sys);
		jog <= 1'b1;
		wr_reg(ADDR_CTRL, 8'h03);
		wait_svc(1'b0, 10);
		settle();
		chk({mpause, mp}, 2'h2);
		rd_reg(ADDR_STATUS, 8'h02);
		@(posedge clk_sys);
		ce <= 1'b0;
		wr_reg(ADDR_CTRL, 8'h07);
		@(posedge clk_sys);
		ce <= 1'b1;
		rd_reg(ADDR_CTRL, 8'h03);
		tdone("safe mode and supply");
		finish_test();
	end
endmodule
